//--- dv/tb_top.sv
// Self-checking bench of the waveform timer channel.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %0t: got %h want %h", $time, g, e); end end
module tb_top;
	// ---------------------------------------------------------------
	// Signals and instances
	// ---------------------------------------------------------------
	localparam [31:0] WV = 32'h8000;
	localparam int DIV [5] = '{2, 8, 32, 128, 1024};
	localparam [7:0] ADR [4] = '{8'h04, 8'h10, 8'h14, 8'h1c};
	reg         i_sys_clk = 1'b0;
	reg         i_sys_rst = 1'b1;
	reg  [7:0]  i_addr    = 8'h0;
	reg  [31:0] i_wdata   = 32'h0;
	reg         i_wr      = 1'b0;
	reg         i_rd      = 1'b0;
	wire [31:0] o_rdata;
	wire [2:0]  xc;
	wire        io_b_m, io_a, a_oe_n, io_b_d, b_oe_n;
	// The b wire follows the channel while it drives, else the far side.
	wire        io_b_w = b_oe_n ? io_b_m : io_b_d;
	int         n_fail = 0;
	int         num_checks = 0;
	int         cyc = 0;
	reg  [31:0] v0, v1;

	always #12.5 i_sys_clk = ~i_sys_clk;

	tcw_top #(.CNT_W(16)) dut_u (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_ext_clock_line_0(xc[0]),
		.i_ext_clock_line_1(xc[1]),
		.i_ext_clock_line_2(xc[2]),
		.i_channel_io_b(io_b_w),
		.o_channel_io_a(io_a),
		.o_channel_io_a_oe_n(a_oe_n),
		.o_channel_io_b(io_b_d),
		.o_channel_io_b_oe_n(b_oe_n)
	);
	tcw_pins_model pm_u (.i_sys_clk(i_sys_clk), .o_xc(xc), .o_io_b(io_b_m));

	// Bus cycles: one strobe cycle each, read data taken in the next cycle.
	task automatic wr(input [7:0] a, input [31:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input [7:0] a, output [31:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		@(negedge i_sys_clk);
		d = o_rdata;
	endtask
	// Count advance between two reads s cycles apart.
	task automatic span(input int s, output [31:0] d);
		rd(8'h10, v0);
		repeat (s - 2) @(posedge i_sys_clk);
		rd(8'h10, v1);
		d = v1 - v0;
	endtask

	task automatic t_regs;
		for (int i = 0; i < 4; i++) begin
			rd(ADR[i], v0);
			`CHK(v0, 32'h0)
		end
		`CHK({a_oe_n, b_oe_n}, 2'b11)
		wr(8'h1c, 32'hffff_1234);
		rd(8'h1c, v0);
		`CHK(v0, 32'h1234)
		wr(8'h14, 32'h55);
		rd(8'h14, v0);
		`CHK(v0, 32'h0)
		wr(8'h04, WV);
		wr(8'h14, 32'h55);
		rd(8'h14, v0);
		`CHK(v0, 32'h55)
		wr(8'h10, 32'h77);
		rd(8'h10, v0);
		`CHK(v0, 32'h0)
	endtask

	task automatic t_clocks;
		wr(8'h1c, 32'hffff);
		for (int i = 0; i < 5; i++) begin
			wr(8'h04, WV | i);
			wr(8'h00, 32'h1);
			span(4 * DIV[i], v0);
			`CHK(v0, 32'h4)
		end
		for (int g = 1; g < 4; g++) begin
			wr(8'h04, WV | (g << 4));
			span(20, v0);
			`CHK(v0, 32'h0)
			pm_u.hold(g - 1, 1'b1);
			span(20, v0);
			`CHK(v0, 32'ha)
			pm_u.hold(g - 1, 1'b0);
		end
		for (int i = 0; i < 6; i++) begin
			wr(8'h04, WV | (5 + i % 3) | ((i / 3) << 3));
			repeat (4) @(posedge i_sys_clk);
			rd(8'h10, v0);
			pm_u.pulse(i % 3, 6);
			repeat (6) @(posedge i_sys_clk);
			rd(8'h10, v1);
			`CHK(v1 - v0, 32'h6)
		end
		wr(8'h04, WV);
		wr(8'h00, 32'h3);
		span(20, v0);
		`CHK(v0, 32'h0)
		wr(8'h00, 32'h1);
		span(20, v0);
		`CHK(v0, 32'ha)
	endtask

	task automatic t_third;
		wr(8'h1c, 32'h5);
		wr(8'h04, WV | 32'h40);
		wr(8'h00, 32'h5);
		repeat (40) @(posedge i_sys_clk);
		span(20, v0);
		`CHK(v0, 32'h0)
		`CHK(v1, 32'h5)
		wr(8'h04, WV | 32'h80);
		wr(8'h00, 32'h5);
		repeat (40) @(posedge i_sys_clk);
		rd(8'h20, v0);
		`CHK(v0[0], 1'b0)
		wr(8'h04, WV | 32'h040c_4400);
		wr(8'h00, 32'h5);
		repeat (40) @(negedge i_sys_clk);
		`CHK(io_b_d, 1'b1)
		v1 = io_a;
		repeat (12) @(negedge i_sys_clk);
		`CHK(io_a, ~v1[0])
		for (int i = 0; i < 8; i++) begin
			rd(8'h10, v0);
			`CHK(v0 <= 32'h5, 1'b1)
		end
	endtask

	task automatic t_soft;
		for (int c = 1; c < 4; c++) begin
			wr(8'h04, WV | 32'h404 | (c << 22) | (c << 30));
			@(negedge i_sys_clk);
			v1 = {io_a, io_b_d};
			wr(8'h00, 32'h5);
			@(negedge i_sys_clk);
			`CHK({io_a, io_b_d}, (c == 3) ? ~v1[1:0] : {2{c == 1}})
			rd(8'h10, v0);
			`CHK(v0 <= 32'h1, 1'b1)
		end
	endtask

	task automatic t_event;
		wr(8'h1c, 32'hffff);
		for (int e = 0; e < 4; e++) begin
			wr(8'h04, WV | 32'h3030_0400 | (e << 8));
			@(negedge i_sys_clk);
			v1 = {io_a, io_b_d};
			pm_u.pulse(0, 1);
			repeat (6) @(negedge i_sys_clk);
			`CHK({io_a, io_b_d}, v1[1:0] ^ {2{e == 1 || e == 2}})
		end
		for (int r = 0; r < 2; r++) begin
			wr(8'h04, WV | 32'h0500 | (r << 12));
			repeat (200) @(posedge i_sys_clk);
			pm_u.pulse(0, 1);
			repeat (4) @(posedge i_sys_clk);
			rd(8'h10, v0);
			`CHK(v0 < 32'h10, r == 1)
		end
		wr(8'h04, WV | 32'h0030_0100);
		@(negedge i_sys_clk);
		v1 = io_a;
		pm_u.pulse(3, 1);
		repeat (6) @(negedge i_sys_clk);
		`CHK(io_a, ~v1[0])
		`CHK(b_oe_n, 1'b1)
	endtask

	task automatic test_done;
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// A hang is cut short well above the few thousand cycles the run needs.
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		t_regs();
		t_clocks();
		t_third();
		t_soft();
		t_event();
		test_done();
	end
endmodule

//--- dv/tcw_pins_model.sv
// Far-side model of the external clock lines and the b channel pin.
`timescale 1ns/1ps
module tcw_pins_model (
	// Clock
	input  wire       i_sys_clk,
	// Lines towards the channel
	output reg  [2:0] o_xc,
	output reg        o_io_b
);
	// Lines rest low and only move when a scenario asks.
	initial begin
		o_xc = 3'h0;
		o_io_b = 1'b0;
	end
	// Hold one line at a level; index 3 is the b pin.
	task automatic hold(input int l, input bit v);
		@(posedge i_sys_clk);
		if (l == 3)
			o_io_b <= v;
		else
			o_xc[l] <= v;
	endtask
	// Pulses of eight cycles, ending low so no stray edge follows.
	task automatic pulse(input int l, input int n);
		repeat (n) begin
			hold(l, 1'b1);
			repeat (3) @(posedge i_sys_clk);
			hold(l, 1'b0);
			repeat (3) @(posedge i_sys_clk);
		end
	endtask
endmodule

//--- dv/tcw_props.sv
// Checker of the register port and channel pins of the timer channel.
`timescale 1ns/1ps
module tcw_props (
	// Clock and reset
	input wire        i_sys_clk,
	input wire        i_sys_rst,
	// Register port
	input wire [7:0]  i_addr,
	input wire [31:0] i_wdata,
	input wire        i_wr,
	input wire        i_rd,
	input wire [31:0] o_rdata,
	// Channel pins
	input wire        o_channel_io_a,
	input wire        o_channel_io_a_oe_n,
	input wire        o_channel_io_b,
	input wire        o_channel_io_b_oe_n
);
	// ---------------------------------------------------------------
	// Shadow registers
	// ---------------------------------------------------------------
	reg  [31:0] mode;
	reg  [15:0] cmp_a;
	reg  [15:0] cmp_c;
	wire        wave = mode[15];
	wire        sw   = i_wr && i_addr == 8'h00 && i_wdata[2] && wave;
	wire        b_on = mode[11:10] != 2'h0;

	// Compare a only follows writes made in waveform operation.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			mode <= 32'h0;
			cmp_a <= 16'h0;
			cmp_c <= 16'h0;
		end else if (i_wr) begin
			if (i_addr == 8'h04)
				mode <= i_wdata;
			if (i_addr == 8'h14 && wave)
				cmp_a <= i_wdata[15:0];
			if (i_addr == 8'h1c)
				cmp_c <= i_wdata[15:0];
		end
	end

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	a_mode_readback: assert property (
		i_rd && i_addr == 8'h04 |=> o_rdata == mode) else $error("mode readback wrong");
	a_cmpa_locked: assert property (
		i_rd && i_addr == 8'h14 |=> o_rdata == {16'h0, cmp_a}) else $error("compare a wrong");
	a_cmpc_readback: assert property (
		i_rd && i_addr == 8'h1c |=> o_rdata == {16'h0, cmp_c}) else $error("compare c wrong");
	a_count_upper: assert property (
		i_rd && i_addr == 8'h10 |=> o_rdata[31:16] == 16'h0) else $error("count upper bits set");
	a_pins_capture: assert property (
		!wave [*3] |-> o_channel_io_a_oe_n && o_channel_io_b_oe_n) else $error("pin driven");
	a_drive_a: assert property (
		wave [*3] |-> !o_channel_io_a_oe_n) else $error("a not driven");
	a_b_input: assert property (
		(wave && !b_on) [*3] |-> o_channel_io_b_oe_n) else $error("b driven as input");
	a_sw_level_a: assert property (
		sw && ^mode[23:22] |=> o_channel_io_a == $past(mode[22])) else $error("a soft level");
	a_sw_toggle_a: assert property (
		sw && &mode[23:22] |=> o_channel_io_a != $past(o_channel_io_a)) else $error("a toggle");
	a_sw_level_b: assert property (
		sw && b_on && ^mode[31:30] |=> o_channel_io_b == $past(mode[30])) else $error("b soft");
endmodule

bind tcw_top tcw_props pr_u (
	.i_sys_clk(i_sys_clk),
	.i_sys_rst(i_sys_rst),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.o_channel_io_a(o_channel_io_a),
	.o_channel_io_a_oe_n(o_channel_io_a_oe_n),
	.o_channel_io_b(o_channel_io_b),
	.o_channel_io_b_oe_n(o_channel_io_b_oe_n)
);

//--- logic/tcw_clk_sel.v
// Prescaler, input synchronisers and counting tick of the timer channel.
`timescale 1ns/1ps
`include "tcw_defs.vh"
module tcw_clk_sel (
	// Clock and reset
	input  wire       i_sys_clk,
	input  wire       i_sys_rst,
	// Configuration
	input  wire [2:0] i_sel,
	input  wire       i_inv,
	input  wire [1:0] i_burst,
	// Asynchronous pins
	input  wire [2:0] i_xc,
	input  wire       i_io_b,
	// Synchronised lines and tick
	output wire [2:0] o_xc_s,
	output wire       o_io_b_s,
	output wire       o_tick
);
	reg  [`TCW_PRE_W-1:0] pre;
	reg  [3:0]            sync1;
	reg  [3:0]            sync2;
	reg                   lvl;
	reg                   gate;
	reg                   prev;
	wire                  cur;

	// ---------------------------------------------------------------
	// Free running prescaler; each tap toggles at half its rate.
	// ---------------------------------------------------------------
	always @(posedge i_sys_clk) begin
		if (i_sys_rst)
			pre <= {`TCW_PRE_W{1'b0}};
		else
			pre <= pre + 1'b1;
	end

	// ---------------------------------------------------------------
	// Two flip-flop synchronisers for every outside line.
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_sync
			always @(posedge i_sys_clk) begin
				if (i_sys_rst) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
				end else begin
					sync1[g] <= (g == 3) ? i_io_b : i_xc[g];
					sync2[g] <= sync1[g];
				end
			end
		end
	endgenerate
	assign o_xc_s   = sync2[2:0];
	assign o_io_b_s = sync2[3];

	// Source selection and gating; external clocks must be slower than half the
	// system clock because they are sampled, not used as clocks.
	always @* begin
		case (i_sel)
			3'h0:    lvl = pre[`TCW_TAP_2];
			3'h1:    lvl = pre[`TCW_TAP_8];
			3'h2:    lvl = pre[`TCW_TAP_32];
			3'h3:    lvl = pre[`TCW_TAP_128];
			3'h4:    lvl = pre[`TCW_TAP_1024];
			3'h5:    lvl = sync2[0];
			3'h6:    lvl = sync2[1];
			default: lvl = sync2[2];
		endcase
		case (i_burst)
			2'h1:    gate = sync2[0];
			2'h2:    gate = sync2[1];
			2'h3:    gate = sync2[2];
			default: gate = 1'b1;
		endcase
	end
	assign cur = lvl & gate;

	// Edge detector; the invert bit picks the falling edge.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst)
			prev <= 1'b0;
		else
			prev <= cur;
	end
	assign o_tick = i_inv ? (prev & ~cur) : (~prev & cur);
endmodule

//--- logic/tcw_defs.vh
// Register map, field positions and codes of the waveform timer channel.
// Operation
// - Clock selector picks divided or external clock, edge
// - Gating field ANDs clock with external line
// - Stop bit halts counting on third match
// - Disable bit disables clock on third match
// - Edge field selects none, rising, falling, both
// - Source field picks I/O b or external line
// - Event restart bit lets event restart counter
// - Third match restart bit restarts counter
// - Mode bit selects waveform or capture operation (cleared, the code only releases both pins; nothing is captured)
// - First match action drives output a
// - Third match action drives output a
// - Event action drives output a
// - Software trigger action drives output a
// - Second match action drives output b
// - Third match action drives output b
// - Event action drives output b
// - Software trigger action drives output b
// - Counter value register is read-only, live
// - First compare writable only in waveform mode
// - Software trigger resets counter, clears stop
// - Enable command works unless disable also given
// - Third compare register readable, writable, resets zero
`ifndef TCW_DEFS_VH
`define TCW_DEFS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define TCW_OFF_CTRL 8'h00
`define TCW_OFF_MODE 8'h04
`define TCW_OFF_CV   8'h10
`define TCW_OFF_RA   8'h14
`define TCW_OFF_RB   8'h18
`define TCW_OFF_RC   8'h1c
`define TCW_OFF_STAT 8'h20

// ---------------------------------------------------------------
// Mode register fields
// ---------------------------------------------------------------
`define TCW_CLKSEL   2:0
`define TCW_INV      3
`define TCW_BURST    5:4
`define TCW_STOP     6
`define TCW_DIS      7
`define TCW_EDG      9:8
`define TCW_EVSRC    11:10
`define TCW_EVRST    12
`define TCW_RCRST    14
`define TCW_WAVE     15
`define TCW_A_M1     17:16
`define TCW_A_M3     19:18
`define TCW_A_EV     21:20
`define TCW_A_SW     23:22
`define TCW_B_M2     25:24
`define TCW_B_M3     27:26
`define TCW_B_EV     29:28
`define TCW_B_SW     31:30

// ---------------------------------------------------------------
// Control and status bits
// ---------------------------------------------------------------
`define TCW_CMD_ON   0
`define TCW_CMD_OFF  1
`define TCW_CMD_SW   2
`define TCW_ST_RUN   0
`define TCW_ST_A     1
`define TCW_ST_B     2
`define TCW_ST_STOP  3

// ---------------------------------------------------------------
// Codes and divider taps
// ---------------------------------------------------------------
`define TCW_ACT_SET  2'h1
`define TCW_ACT_CLR  2'h2
`define TCW_ACT_TOG  2'h3
`define TCW_EDG_RISE 2'h1
`define TCW_EDG_FALL 2'h2
`define TCW_EDG_BOTH 2'h3
`define TCW_SRC_IOB  2'h0
`define TCW_PRE_W    10
`define TCW_TAP_2    0
`define TCW_TAP_8    2
`define TCW_TAP_32   4
`define TCW_TAP_128  6
`define TCW_TAP_1024 9

`endif

//--- logic/tcw_out_action.v
// Set, clear or toggle action applied to one channel output.
`timescale 1ns/1ps
`include "tcw_defs.vh"
module tcw_out_action (
	// Present level
	input  wire       i_cur,
	// Sources in falling priority
	input  wire       i_sw_hit,
	input  wire [1:0] i_sw_act,
	input  wire       i_ev_hit,
	input  wire [1:0] i_ev_act,
	input  wire       i_m3_hit,
	input  wire [1:0] i_m3_act,
	input  wire       i_mx_hit,
	input  wire [1:0] i_mx_act,
	// Next level
	output reg        o_next
);
	reg [1:0] act;

	// Only the highest active source acts, so simultaneous events never
	// stack two toggles into no change.
	always @* begin
		if (i_sw_hit)
			act = i_sw_act;
		else if (i_ev_hit)
			act = i_ev_act;
		else if (i_m3_hit)
			act = i_m3_act;
		else if (i_mx_hit)
			act = i_mx_act;
		else
			act = 2'h0;
		case (act)
			`TCW_ACT_SET: o_next = 1'b1;
			`TCW_ACT_CLR: o_next = 1'b0;
			`TCW_ACT_TOG: o_next = ~i_cur;
			default:      o_next = i_cur;
		endcase
	end
endmodule

//--- logic/tcw_top.v
// Top of one 16-bit timer channel in waveform mode with its register port.
`timescale 1ns/1ps
`include "tcw_defs.vh"
module tcw_top #(
	parameter CNT_W = 16
) (
	// Clock and reset
	input  wire             i_sys_clk,
	input  wire             i_sys_rst,
	// Register port
	input  wire [7:0]       i_addr,
	input  wire [31:0]      i_wdata,
	input  wire             i_wr,
	input  wire             i_rd,
	output reg  [31:0]      o_rdata,
	// External clock lines
	input  wire             i_ext_clock_line_0,
	input  wire             i_ext_clock_line_1,
	input  wire             i_ext_clock_line_2,
	// Channel pins
	input  wire             i_channel_io_b,
	output reg              o_channel_io_a,
	output reg              o_channel_io_a_oe_n,
	output reg              o_channel_io_b,
	output reg              o_channel_io_b_oe_n
);
	// ---------------------------------------------------------------
	// Registers and state
	// ---------------------------------------------------------------
	reg  [31:0]      mode;
	reg  [CNT_W-1:0] count_value;
	reg  [CNT_W-1:0] first_compare;
	reg  [CNT_W-1:0] second_compare;
	reg  [CNT_W-1:0] third_compare;
	reg              clk_on;
	reg              stopped;
	reg              ev_prev;
	reg              ev_lvl;
	reg              ev_hit;
	reg  [CNT_W-1:0] next_count;
	reg  [31:0]      next_rdata;

	wire [2:0]       xc_s;
	wire             io_b_s;
	wire             tick;
	wire             wave;
	wire             run;
	wire             step;
	wire             hit1;
	wire             hit2;
	wire             hit3;
	wire             wr_ctrl;
	wire             cmd_on;
	wire             cmd_off;
	wire             sw_trig;
	wire             ev_trig;
	wire             m3_trig;
	wire             restart;
	wire             b_is_input;
	wire             next_a;
	wire             next_b;

	// ---------------------------------------------------------------
	// Counting clock source
	// ---------------------------------------------------------------
	tcw_clk_sel u_clk_sel (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_sel     (mode[`TCW_CLKSEL]),
		.i_inv     (mode[`TCW_INV]),
		.i_burst   (mode[`TCW_BURST]),
		.i_xc      ({i_ext_clock_line_2, i_ext_clock_line_1, i_ext_clock_line_0}),
		.i_io_b    (i_channel_io_b),
		.o_xc_s    (xc_s),
		.o_io_b_s  (io_b_s),
		.o_tick    (tick)
	);

	// ---------------------------------------------------------------
	// Mode and command decode
	// ---------------------------------------------------------------
	assign wave       = mode[`TCW_WAVE];
	assign wr_ctrl    = i_wr && (i_addr == `TCW_OFF_CTRL);
	assign cmd_off    = wr_ctrl && i_wdata[`TCW_CMD_OFF];
	assign cmd_on     = wr_ctrl && i_wdata[`TCW_CMD_ON] && !cmd_off;
	assign sw_trig    = wr_ctrl && i_wdata[`TCW_CMD_SW];
	assign b_is_input = (mode[`TCW_EVSRC] == `TCW_SRC_IOB);

	// Counting only while enabled and not halted by a third match.
	assign run  = clk_on && !stopped;
	assign step = tick && run;

	// A match is judged in the counting cycle, on the value being left.
	assign hit1 = step && (count_value == first_compare);
	assign hit2 = step && (count_value == second_compare);
	assign hit3 = step && (count_value == third_compare);

	// ---------------------------------------------------------------
	// External event selection and edge detection
	// ---------------------------------------------------------------
	always @* begin
		case (mode[`TCW_EVSRC])
			2'h1:    ev_lvl = xc_s[0];
			2'h2:    ev_lvl = xc_s[1];
			2'h3:    ev_lvl = xc_s[2];
			default: ev_lvl = io_b_s;
		endcase
		case (mode[`TCW_EDG])
			`TCW_EDG_RISE: ev_hit = ev_lvl && !ev_prev;
			`TCW_EDG_FALL: ev_hit = !ev_lvl && ev_prev;
			`TCW_EDG_BOTH: ev_hit = ev_lvl != ev_prev;
			default:       ev_hit = 1'b0;
		endcase
	end

	// Previous event level, compared with the synchronised one.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst)
			ev_prev <= 1'b0;
		else
			ev_prev <= ev_lvl;
	end

	// Triggers that reset the counter and clear its stop state.
	assign ev_trig = ev_hit && mode[`TCW_EVRST];
	assign m3_trig = hit3 && mode[`TCW_RCRST];
	assign restart = sw_trig || ev_trig || m3_trig;

	// ---------------------------------------------------------------
	// Counter
	// ---------------------------------------------------------------
	// A restart wins over counting, so a trigger in a tick cycle yields zero.
	// A third match that stops or disables the clock holds the count on the
	// compare value instead of stepping past it.
	always @* begin
		if (restart)
			next_count = {CNT_W{1'b0}};
		else if (step && !(hit3 && (mode[`TCW_STOP] || mode[`TCW_DIS])))
			next_count = count_value + 1'b1;
		else
			next_count = count_value;
	end

	always @(posedge i_sys_clk) begin
		if (i_sys_rst)
			count_value <= {CNT_W{1'b0}};
		else
			count_value <= next_count;
	end

	// ---------------------------------------------------------------
	// Clock enable and stop state
	// ---------------------------------------------------------------
	// Disable has priority over every enabling source; a restart clears
	// only the stop, so a disabled clock needs the enable command.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			clk_on  <= 1'b0;
			stopped <= 1'b0;
		end else begin
			if (cmd_off)
				clk_on <= 1'b0;
			else if (hit3 && mode[`TCW_DIS])
				clk_on <= 1'b0;
			else if (cmd_on)
				clk_on <= 1'b1;
			if (restart)
				stopped <= 1'b0;
			else if (hit3 && mode[`TCW_STOP])
				stopped <= 1'b1;
			else if (cmd_on)
				stopped <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Output actions
	// ---------------------------------------------------------------
	tcw_out_action u_act_a (
		.i_cur    (o_channel_io_a),
		.i_sw_hit (sw_trig),
		.i_sw_act (mode[`TCW_A_SW]),
		.i_ev_hit (ev_hit),
		.i_ev_act (mode[`TCW_A_EV]),
		.i_m3_hit (hit3),
		.i_m3_act (mode[`TCW_A_M3]),
		.i_mx_hit (hit1),
		.i_mx_act (mode[`TCW_A_M1]),
		.o_next   (next_a)
	);

	tcw_out_action u_act_b (
		.i_cur    (o_channel_io_b),
		.i_sw_hit (sw_trig),
		.i_sw_act (mode[`TCW_B_SW]),
		.i_ev_hit (ev_hit),
		.i_ev_act (mode[`TCW_B_EV]),
		.i_m3_hit (hit3),
		.i_m3_act (mode[`TCW_B_M3]),
		.i_mx_hit (hit2),
		.i_mx_act (mode[`TCW_B_M2]),
		.o_next   (next_b)
	);

	// Pins are driven only in waveform operation; line b turns to an
	// input while it serves as the event source.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_channel_io_a      <= 1'b0;
			o_channel_io_b      <= 1'b0;
			o_channel_io_a_oe_n <= 1'b1;
			o_channel_io_b_oe_n <= 1'b1;
		end else begin
			o_channel_io_a_oe_n <= !wave;
			o_channel_io_b_oe_n <= !wave || b_is_input;
			if (wave)
				o_channel_io_a <= next_a;
			if (wave && !b_is_input)
				o_channel_io_b <= next_b;
		end
	end

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	// Compare registers a and b follow the mode bit already stored, so a
	// write that sets the mode takes effect for the next access.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			mode           <= 32'h0000_0000;
			first_compare  <= {CNT_W{1'b0}};
			second_compare <= {CNT_W{1'b0}};
			third_compare  <= {CNT_W{1'b0}};
		end else if (i_wr) begin
			case (i_addr)
				`TCW_OFF_MODE: mode <= i_wdata;
				`TCW_OFF_RA: begin
					if (wave)
						first_compare <= i_wdata[CNT_W-1:0];
				end
				`TCW_OFF_RB: begin
					if (wave)
						second_compare <= i_wdata[CNT_W-1:0];
				end
				`TCW_OFF_RC: third_compare <= i_wdata[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Register reads
	// ---------------------------------------------------------------
	// Unmapped offsets and the command register read as zero.
	always @* begin
		next_rdata = 32'h0000_0000;
		case (i_addr)
			`TCW_OFF_MODE: next_rdata = mode;
			`TCW_OFF_CV:   next_rdata[CNT_W-1:0] = count_value;
			`TCW_OFF_RA:   next_rdata[CNT_W-1:0] = first_compare;
			`TCW_OFF_RB:   next_rdata[CNT_W-1:0] = second_compare;
			`TCW_OFF_RC:   next_rdata[CNT_W-1:0] = third_compare;
			`TCW_OFF_STAT: begin
				next_rdata[`TCW_ST_RUN]  = clk_on;
				next_rdata[`TCW_ST_A]    = o_channel_io_a;
				next_rdata[`TCW_ST_B]    = o_channel_io_b;
				next_rdata[`TCW_ST_STOP] = stopped;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data are registered and hold until the next read strobe.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst)
			o_rdata <= 32'h0000_0000;
		else if (i_rd)
			o_rdata <= next_rdata;
	end
endmodule
